// *** core/cpsm_pkg.sv ***
// Constants, register map and state record of the config port status monitor.
// Assumes one 25 MHz clock, synchronous active-high reset and a Wishbone slave port.
package cpsm_pkg;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_ISTAT = 8'h08;
    localparam logic [7:0] REG_FRAMES = 8'h0C;
    localparam logic [7:0] REG_GEOM = 8'h10;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_GSR_AFTER = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int ISTAT_CRC_ERR = 0;
    localparam int ISTAT_PER_ELEMENT = 1;
    localparam logic [3:0] NIB_OLD = 4'hF;
    localparam logic [3:0] NIB_NEW = 4'hB;
    localparam logic [3:0] ST_IDLE = 4'h9;
    localparam logic [3:0] ST_SYNC = 4'hD;
    localparam logic [3:0] ST_SYNC_ERR = 4'h5;
    localparam logic [3:0] ST_ERR = 4'h1;
    localparam logic [31:0] WORD_SYNC = 32'h5A5A0001;
    localparam logic [31:0] WORD_CRC_RESET = 32'h5A5A0002;
    localparam logic [31:0] WORD_END_SYNC = 32'h5A5A0003;
    localparam logic [31:0] WORD_FRAME_WRITE = 32'h5A5A0004;
    localparam logic [7:0] OLD_LOGIC_H = 8'h32;
    localparam logic [7:0] OLD_MULT_H = 8'h0A;
    localparam logic [7:0] OLD_MEM_H = 8'h0A;
    localparam logic [7:0] NEW_LOGIC_H = 8'h3C;
    localparam logic [7:0] NEW_MULT_H = 8'h18;
    localparam logic [7:0] NEW_MEM_H = 8'h0C;
    localparam logic [7:0] NEW_XCVR_H = 8'h04;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_SYNC = 3'b010,
        PH_FRAME = 3'b100
    } cpsm_phase_t;

    typedef struct packed {
        cpsm_phase_t phase;
        logic err;
        logic drop_sync;
        logic [15:0] word_cnt;
        logic [15:0] frame_cnt;
        logic crc_flag;
        logic global_set_reset;
        logic [1:0] ctrl;
        logic [7:0] status;
        logic done_m;
        logic done_s;
        logic init_m;
        logic init_s;
        logic init_oe_n;
        logic ack;
        logic [31:0] rdata;
    } cpsm_state_t;

    localparam cpsm_state_t STATE_RESET = '{
        phase: PH_IDLE, err: 1'b0, drop_sync: 1'b0, word_cnt: 16'h0000,
        frame_cnt: 16'h0000, crc_flag: 1'b0, global_set_reset: 1'b0, ctrl: CTRL_RESET,
        status: 8'h00, done_m: 1'b0, done_s: 1'b0, init_m: 1'b1,
        init_s: 1'b1, init_oe_n: 1'b1, ack: 1'b0, rdata: 32'h00000000};
endpackage

// *** core/cpsm_monitor.sv ***
// Status monitor of the internal configuration port: decodes the bitstream word
// stream, keeps the status byte, drives the init fault pin and serves Wishbone.
// Assumes crc_bad inputs and readback/abort levels come from logic on clk_i.
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module cpsm_monitor #(
    parameter bit NEWER_FAMILY = 1'b0,
    parameter int FRAME_WORDS = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [31:0] word_i,
    input wire logic word_valid_i,
    input wire logic file_crc_bad_i,
    input wire logic frame_crc_bad_i,
    input wire logic readback_i,
    input wire logic abort_i,
    input wire logic done_pin_i,
    input wire logic init_pin_i,
    output logic init_pin_o,
    output logic init_pin_oe_n_o,
    output logic [31:0] status_o,
    output logic partial_load_complete_o,
    output logic partial_load_fault_o,
    output logic global_set_reset_o,
    output logic gsr_whole_column_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    localparam logic [3:0] NIB = NEWER_FAMILY ? cpsm_pkg::NIB_NEW : cpsm_pkg::NIB_OLD;
    localparam logic [15:0] LAST_WORD = 16'(FRAME_WORDS - 1);

    initial begin
        if (FRAME_WORDS < 1 || FRAME_WORDS > 65536) begin
            $error("FRAME_WORDS must lie in 1..65536");
        end
    end

    cpsm_pkg::cpsm_state_t s;
    cpsm_pkg::cpsm_state_t n;
    logic take;
    logic err_ev;
    logic frame_end;
    logic [31:0] geom;

    // Geometry is fixed by the family; it only tells software how big a region is
    always_comb begin
        if (NEWER_FAMILY) begin
            geom = {cpsm_pkg::NEW_XCVR_H, cpsm_pkg::NEW_MEM_H,
                    cpsm_pkg::NEW_MULT_H, cpsm_pkg::NEW_LOGIC_H};
        end else begin
            geom = {8'h00, cpsm_pkg::OLD_MEM_H,
                    cpsm_pkg::OLD_MULT_H, cpsm_pkg::OLD_LOGIC_H};
        end
    end

    always_comb begin
        n = s;
        n.ack = 1'b0;
        n.global_set_reset = 1'b0;
        take = word_valid_i && s.ctrl[cpsm_pkg::CTRL_ENABLE];
        frame_end = take && s.phase == cpsm_pkg::PH_FRAME && s.word_cnt == LAST_WORD;
        err_ev = (file_crc_bad_i && s.phase != cpsm_pkg::PH_IDLE)
            || (frame_end && frame_crc_bad_i);
        // Pins from outside are resynchronised before anything looks at them
        n.done_m = done_pin_i;
        n.done_s = s.done_m;
        n.init_m = init_pin_i;
        n.init_s = s.init_m;
        if (take) begin
            unique case (s.phase)
                cpsm_pkg::PH_IDLE: begin
                    if (word_i == cpsm_pkg::WORD_SYNC) begin
                        n.phase = cpsm_pkg::PH_SYNC;
                    end
                end
                cpsm_pkg::PH_SYNC: begin
                    if (word_i == cpsm_pkg::WORD_CRC_RESET) begin
                        n.err = 1'b0;
                        n.crc_flag = 1'b0;
                    end else if (word_i == cpsm_pkg::WORD_END_SYNC) begin
                        // A end_sync_command with a standing error keeps the port synced
                        if (!s.err) begin
                            n.phase = cpsm_pkg::PH_IDLE;
                            n.global_set_reset = s.ctrl[cpsm_pkg::CTRL_GSR_AFTER];
                        end
                    end else if (word_i == cpsm_pkg::WORD_FRAME_WRITE) begin
                        n.phase = cpsm_pkg::PH_FRAME;
                        n.word_cnt = 16'h0000;
                    end
                end
                cpsm_pkg::PH_FRAME: begin
                    // Inside a frame every word is data, so commands cannot split it
                    n.word_cnt = 16'(s.word_cnt + 16'h0001);
                    if (frame_end) begin
                        n.phase = cpsm_pkg::PH_SYNC;
                        if (!frame_crc_bad_i) begin
                            n.frame_cnt = 16'(s.frame_cnt + 16'h0001);
                        end
                    end
                end
            endcase
        end
        // Error is applied after the CRC reset so that a coincident error wins
        if (err_ev) begin
            n.err = 1'b1;
            n.crc_flag = 1'b1;
            n.drop_sync = 1'b1;
        end
        // Sync falls one cycle after the error so 5F is visible exactly once
        if (s.drop_sync) begin
            n.phase = cpsm_pkg::PH_IDLE;
            n.drop_sync = 1'b0;
        end
        n.init_oe_n = !n.err;
        n.status = {!n.err, n.phase != cpsm_pkg::PH_IDLE,
                    readback_i, !abort_i, NIB};
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
            n.ack = 1'b1;
            if (wb_we_i && wb_adr_i == cpsm_pkg::REG_CTRL && wb_sel_i[0]) begin
                n.ctrl = wb_dat_i[1:0];
            end
            unique case (wb_adr_i)
                cpsm_pkg::REG_STATUS: n.rdata = {24'h000000, s.status};
                cpsm_pkg::REG_CTRL: n.rdata = {30'h00000000, s.ctrl};
                cpsm_pkg::REG_ISTAT: n.rdata = {30'h00000000, NEWER_FAMILY,
                                                 s.crc_flag};
                cpsm_pkg::REG_FRAMES: n.rdata = {16'h0000, s.frame_cnt};
                cpsm_pkg::REG_GEOM: n.rdata = geom;
                default: n.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= cpsm_pkg::STATE_RESET;
        end else if (ce_i) begin
            s <= n;
        end
    end

    assign status_o = {24'h000000, s.status};
    assign init_pin_o = 1'b0;
    assign init_pin_oe_n_o = s.init_oe_n;
    assign partial_load_complete_o = s.done_s;
    assign partial_load_fault_o = s.init_s;
    assign global_set_reset_o = s.global_set_reset;
    assign gsr_whole_column_o = !NEWER_FAMILY;
    assign wb_dat_o = s.rdata;
    assign wb_ack_o = s.ack;

    upper_zero_a: assert property (
        @(posedge clk_i) disable iff (rst_i) status_o[31:8] == 24'h000000)
        else $error("status bits above the low byte are not zero");

    low_nibble_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(ce_i) && !$past(rst_i) |-> status_o[3:0] == NIB)
        else $error("reserved status nibble wrong");

    fault_pin_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(ce_i) && !$past(rst_i) |-> status_o[7] == init_pin_oe_n_o)
        else $error("fault bit and init drive disagree");

    error_hold_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && s.drop_sync |=> status_o[7:4] == cpsm_pkg::ST_ERR && !init_pin_oe_n_o)
        else $error("error state did not settle to 1x");

    error_seen_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && err_ev && s.phase == cpsm_pkg::PH_SYNC && !s.drop_sync
        |=> status_o[7:4] == cpsm_pkg::ST_SYNC_ERR ##0 s.drop_sync)
        else $error("CRC error did not show 5x first");

    sync_rise_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && take && s.phase == cpsm_pkg::PH_IDLE && word_i == cpsm_pkg::WORD_SYNC
        && !s.drop_sync |=> status_o[6])
        else $error("sync word not reflected");

    crc_reset_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && take && s.phase == cpsm_pkg::PH_SYNC && !s.drop_sync
        && word_i == cpsm_pkg::WORD_CRC_RESET && !file_crc_bad_i
        |=> status_o[7:4] == cpsm_pkg::ST_SYNC && init_pin_oe_n_o && !s.crc_flag)
        else $error("CRC reset did not clear the fault");

    end_sync_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && take && s.phase == cpsm_pkg::PH_SYNC && !s.drop_sync && !s.err
        && word_i == cpsm_pkg::WORD_END_SYNC && !file_crc_bad_i
        |=> status_o[7:4] == cpsm_pkg::ST_IDLE)
        else $error("end-sync did not return to idle");

    fault_mirror_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i [*2] |=> partial_load_fault_o == $past(init_pin_i, 2))
        else $error("fault output does not follow init pin");

    done_mirror_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i [*2] |=> partial_load_complete_o == $past(done_pin_i, 2))
        else $error("complete output does not follow done pin");

    frame_count_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) && $changed(s.frame_cnt)
        |-> $past(s.phase) == cpsm_pkg::PH_FRAME && $past(s.word_cnt) == LAST_WORD)
        else $error("frame counted before it was whole");

    crc_flag_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ce_i && err_ev |=> s.crc_flag && wb_ack_o == $past(n.ack))
        else $error("CRC flag not set on error");
endmodule

// *** dv/cpsm_ctrl_model.sv ***
// Model of the fabric reconfiguration controller that feeds the port.
// Assumes clk_i is the port clock; send is entered just after a rising edge.
`timescale 1ns/1ps
module cpsm_ctrl_model (
    input wire logic clk_i,
    input wire logic [31:0] status_i,
    output logic [31:0] word_o,
    output logic word_valid_o,
    output logic [3:0] link_o
);
    // Bits 31..8 and the low nibble are never decoded
    assign link_o = status_i[7:4];
    initial begin
        word_o = 32'h00000000;
        word_valid_o = 1'b0;
    end
    // Released data is inverted so a stale word never passes for a fresh one
    task automatic send(input logic [31:0] w[$]);
        foreach (w[i]) begin
            word_o <= w[i];
            word_valid_o <= 1'b1;
            @(posedge clk_i);
        end
        word_o <= ~word_o;
        word_valid_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule

// *** dv/config_port_status_monitor_tb_top.sv ***
// Self-checking bench: Wishbone tasks plus word bursts from the controller model.
// Assumes the older family and two-word frames to keep frame runs short.
`timescale 1ns/1ps
module config_port_status_monitor_tb_top;
    logic clk = 1'b0, rst = 1'b1, fcrc = 1'b0, frcrc = 1'b0, rb = 1'b0, ab = 1'b1;
    logic done = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000, rd, word;
    logic [3:0] sel = 4'h0, link;
    logic vld, ipo, ioe_n, ipi, plc, plf, global_set_reset, gcol, ack;
    logic [31:0] st_o, dat_o;
    int errors = 0, comparisons = 0, cycles = 0, gsr_seen = 0, n5;
    always #20 clk = ~clk;
    // Open-drain init line with its pull-up
    assign ipi = ioe_n ? 1'b1 : ipo;
    cpsm_monitor #(.NEWER_FAMILY(1'b0), .FRAME_WORDS(2)) cpsm_monitor_inst (
        .clk_i(clk), .rst_i(rst), .ce_i(1'b1), .word_i(word), .word_valid_i(vld),
        .file_crc_bad_i(fcrc), .frame_crc_bad_i(frcrc), .readback_i(rb), .abort_i(!ab),
        .done_pin_i(done), .init_pin_i(ipi), .init_pin_o(ipo), .init_pin_oe_n_o(ioe_n),
        .status_o(st_o), .partial_load_complete_o(plc), .partial_load_fault_o(plf),
        .global_set_reset_o(global_set_reset), .gsr_whole_column_o(gcol), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_dat_o(dat_o), .wb_ack_o(ack));
    cpsm_ctrl_model cpsm_ctrl_model_inst (.clk_i(clk), .status_i(st_o), .word_o(word),
        .word_valid_o(vld), .link_o(link));
    task automatic complete_run();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (global_set_reset === 1'b1) gsr_seen <= gsr_seen + 1;
        if (cycles == 4000) begin
            errors = errors + 1;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic st(input logic [7:0] e);
        repeat (3) @(posedge clk);
        #1 chk(st_o, {24'h000000, e});
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        st(8'h9F);
        wb(1'b1, cpsm_pkg::REG_STATUS, 32'h00000000);
        wb(1'b0, cpsm_pkg::REG_STATUS, 32'h00000000);
        chk(rd[7:0], 8'h9F);
        wb(1'b0, cpsm_pkg::REG_GEOM, 32'h00000000);
        chk(rd[23:0], 24'h0A0A32);
        wb(1'b0, cpsm_pkg::REG_ISTAT, 32'h00000000);
        chk(rd[1], 1'b0);
        chk(gcol, 1'b1);
        wb(1'b0, 8'h20, 32'h00000000);
        chk(rd, 32'h00000000);
        cpsm_ctrl_model_inst.send('{cpsm_pkg::WORD_SYNC});
        st(8'hDF);
        rb <= 1'b1;
        st(8'hFF);
        rb <= 1'b0;
        ab <= 1'b0;
        st(8'hCF);
        ab <= 1'b1;
        cpsm_ctrl_model_inst.send('{cpsm_pkg::WORD_FRAME_WRITE, 32'h12345678, 32'h9ABCDEF0});
        wb(1'b0, cpsm_pkg::REG_FRAMES, 32'h00000000);
        chk(rd[15:0], 16'h0001);
        fcrc <= 1'b1;
        @(posedge clk);
        fcrc <= 1'b0;
        n5 = 0;
        // 5F stands only from the error edge to the next, so sample from that edge on
        repeat (4) begin
            #1 if (st_o[7:0] === 8'h5F) n5++;
            @(posedge clk);
        end
        chk(n5, 1);
        chk(st_o, 32'h1F);
        chk(ioe_n, 1'b0);
        chk(plf, 1'b0);
        wb(1'b0, cpsm_pkg::REG_ISTAT, 32'h00000000);
        chk(rd[0], 1'b1);
        // Retry the load as a recovering controller would
        cpsm_ctrl_model_inst.send('{cpsm_pkg::WORD_SYNC});
        st(8'h5F);
        cpsm_ctrl_model_inst.send('{cpsm_pkg::WORD_CRC_RESET});
        st(8'hDF);
        chk(ioe_n, 1'b1);
        wb(1'b0, cpsm_pkg::REG_ISTAT, 32'h00000000);
        chk(rd[0], 1'b0);
        wb(1'b1, cpsm_pkg::REG_CTRL, 32'h00000003);
        cpsm_ctrl_model_inst.send('{cpsm_pkg::WORD_END_SYNC});
        st(8'h9F);
        chk(gsr_seen, 1);
        chk(plf, 1'b1);
        cpsm_ctrl_model_inst.send('{cpsm_pkg::WORD_SYNC});
        frcrc <= 1'b1;
        cpsm_ctrl_model_inst.send('{cpsm_pkg::WORD_FRAME_WRITE, 32'h0F0F0F0F, 32'hF0F0F0F0});
        frcrc <= 1'b0;
        st(8'h1F);
        wb(1'b0, cpsm_pkg::REG_FRAMES, 32'h00000000);
        chk(rd[15:0], 16'h0001);
        done <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk(plc, 1'b1);
        complete_run();
    end
endmodule
